// File: rtcs_target.sv
// two-wire serial target port: bus sequencer on link_clk, register pointer on clk
//
// How it works
// - First byte after START is an address; answer only if top seven bits match.
// - Direction bit zero means the controller writes bytes to the device.
// - Direction bit one means the device sends bytes to the controller.
// - A matching address byte is acknowledged by pulling data low on pulse nine.
// - First written byte after the address loads the register pointer and is acknowledged.
// - Every byte received in write mode gets an acknowledge.
// - Each written data byte goes to the pointer location, then the pointer increments.
// - A read starts at the current pointer, whatever value it last held.
// - The pointer increments after every byte sent in a read.
// - All bytes move most significant bit first.
// - On a not-acknowledge the device stops sending and releases the data line.
// - A transfer ends in STOP or repeated START; repeated START expects a new address.
// - START and STOP are detected anywhere and restart or end the byte sequence.
// - In reads the device drives data while clock is only an input.
// - On START the running time is copied to holding registers for a steady read.
// - A written byte is committed when the device drives its acknowledge.
// - Clock low past the timeout resets the interface until the next START.
`timescale 1ns/10ps
`default_nettype none

module rtcs_target #(
    parameter int TIMEOUT_CYCLES = rtcs_pkg::TIMEOUT_CYCLES
) (
    // register-side clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // link oversampling clock
    input  wire logic       link_clk,
    // bus pins, clock is input only
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    // register space access
    output logic [7:0]      reg_addr,
    output logic            reg_wr_en,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata,
    // time snapshot request
    output logic            snap_strobe
);

    ////////////////////////////////////////////////////////////////////////////
    // link domain: reset release and pin synchronisers

    logic                        link_rst_s1;
    logic                        link_rst;
    logic                        scl_s1;
    logic                        scl_s2;
    logic                        scl_d;
    logic                        sda_s1;
    logic                        sda_s2;
    logic                        sda_d;
    logic                        to_s1;
    logic                        to_s2;
    logic                        to_d;
    logic                        ack_s1;
    logic                        ack_s2;

    // clk-domain handshake and timeout state, declared early for the link side
    logic                        ack_tgl;
    logic                        to_tgl;
    logic [7:0]                  rd_byte;

    always_ff @(posedge link_clk or posedge reset)
    begin
        if (reset)
        begin
            link_rst_s1 <= 1'b1;
            link_rst    <= 1'b1;
        end
        else
        begin
            link_rst_s1 <= 1'b0;
            link_rst    <= link_rst_s1;
        end
    end

    // idle bus is high on both lines
    always_ff @(posedge link_clk or posedge link_rst)
    begin
        if (link_rst)
        begin
            {scl_s1, scl_s2, scl_d} <= 3'h7;
            {sda_s1, sda_s2, sda_d} <= 3'h7;
            {to_s1, to_s2, to_d}    <= 3'h0;
            {ack_s1, ack_s2}        <= 2'h0;
        end
        else
        begin
            {scl_s1, scl_s2, scl_d} <= {scl_i, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_d} <= {sda_i, sda_s1, sda_s2};
            {to_s1, to_s2, to_d}    <= {to_tgl, to_s1, to_s2};
            {ack_s1, ack_s2}        <= {ack_tgl, ack_s1};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link domain: bus condition decode

    rtcs_pkg::rtcs_link_state_t  state;
    rtcs_pkg::rtcs_link_state_t  next_state;
    logic [3:0]                  bitcnt;
    logic [3:0]                  next_bitcnt;
    logic [7:0]                  shift;
    logic [7:0]                  next_shift;
    logic [7:0]                  tx;
    logic [7:0]                  next_tx;
    logic                        is_read;
    logic                        next_is_read;
    logic                        ptr_phase;
    logic                        next_ptr_phase;
    logic                        master_ack;
    logic                        next_master_ack;
    logic                        next_sda_oe;
    logic                        req_tgl;
    logic                        next_req_tgl;
    logic                        start_tgl;
    logic                        next_start_tgl;
    rtcs_pkg::rtcs_event_t       ev;
    rtcs_pkg::rtcs_event_t       next_ev;

    wire scl_rise   = scl_s2 & ~scl_d;
    wire scl_fall   = ~scl_s2 & scl_d;
    wire bus_start  = scl_s2 & scl_d & sda_d & ~sda_s2;
    wire bus_stop   = scl_s2 & scl_d & ~sda_d & sda_s2;
    wire timeout_ev = to_s2 ^ to_d;
    wire addr_match = (shift[7:1] == rtcs_pkg::DEV_ADDR);
    wire byte_in    = (bitcnt == rtcs_pkg::BIT_DONE);
    wire load_tx    = ((state == rtcs_pkg::LS_ACK) & is_read)
                    | ((state == rtcs_pkg::LS_TXACK) & master_ack);
    wire [7:0] rx_next = {shift[6:0], sda_s2};

    ////////////////////////////////////////////////////////////////////////////
    // link domain: byte sequencer

    always_comb
    begin
        next_state      = state;
        next_bitcnt     = bitcnt;
        next_shift      = shift;
        next_tx         = tx;
        next_is_read    = is_read;
        next_ptr_phase  = ptr_phase;
        next_master_ack = master_ack;
        next_sda_oe     = sda_oe;
        next_req_tgl    = req_tgl;
        next_start_tgl  = start_tgl;
        next_ev         = ev;
        if (timeout_ev)
        begin
            // back to waiting for a START
            next_state  = rtcs_pkg::LS_IDLE;
            next_sda_oe = 1'b0;
        end
        else if (bus_start)
        begin
            // also a repeated START: fresh address byte follows
            next_state     = rtcs_pkg::LS_ADDR;
            next_bitcnt    = rtcs_pkg::BIT_FIRST;
            next_sda_oe    = 1'b0;
            next_start_tgl = ~start_tgl;
        end
        else if (bus_stop)
        begin
            next_state  = rtcs_pkg::LS_IDLE;
            next_sda_oe = 1'b0;
        end
        else
        begin
            case (state)
                rtcs_pkg::LS_IDLE:
                begin
                    next_sda_oe = 1'b0;
                end
                rtcs_pkg::LS_ADDR, rtcs_pkg::LS_RX:
                begin
                    if (scl_rise && !byte_in)
                    begin
                        next_shift  = rx_next;
                        next_bitcnt = bitcnt + 4'h1;
                    end
                    else if (scl_fall && byte_in)
                    begin
                        if (state == rtcs_pkg::LS_RX)
                        begin
                            // commit travels with the acknowledge edge
                            next_sda_oe    = 1'b1;
                            next_state     = rtcs_pkg::LS_ACK;
                            next_ptr_phase = 1'b0;
                            next_req_tgl   = ~req_tgl;
                            next_ev.data   = shift;
                            next_ev.kind   = ptr_phase ? rtcs_pkg::EV_PTR
                                                       : rtcs_pkg::EV_WR;
                        end
                        else if (addr_match)
                        begin
                            next_sda_oe    = 1'b1;
                            next_state     = rtcs_pkg::LS_ACK;
                            next_is_read   = shift[0];
                            next_ptr_phase = 1'b1;
                            if (shift[0])
                            begin
                                next_req_tgl = ~req_tgl;
                                next_ev.kind = rtcs_pkg::EV_RD;
                                next_ev.data = rtcs_pkg::BYTE_RESET;
                            end
                        end
                        else
                        begin
                            next_state = rtcs_pkg::LS_IDLE;
                        end
                    end
                end
                rtcs_pkg::LS_ACK, rtcs_pkg::LS_TXACK:
                begin
                    if (scl_rise && state == rtcs_pkg::LS_TXACK)
                    begin
                        next_master_ack = ~sda_s2;
                    end
                    else if (scl_fall)
                    begin
                        next_bitcnt = rtcs_pkg::BIT_FIRST;
                        if (load_tx)
                        begin
                            next_tx      = rd_byte;
                            next_sda_oe  = ~rd_byte[7];
                            next_state   = rtcs_pkg::LS_TX;
                            next_req_tgl = ~req_tgl;
                            next_ev.kind = rtcs_pkg::EV_SENT;
                            next_ev.data = rtcs_pkg::BYTE_RESET;
                        end
                        else if (state == rtcs_pkg::LS_ACK)
                        begin
                            next_sda_oe = 1'b0;
                            next_state  = rtcs_pkg::LS_RX;
                        end
                        else
                        begin
                            // not-acknowledge: line stays released
                            next_sda_oe = 1'b0;
                            next_state  = rtcs_pkg::LS_IDLE;
                        end
                    end
                end
                rtcs_pkg::LS_TX:
                begin
                    if (scl_fall)
                    begin
                        if (bitcnt == rtcs_pkg::BIT_LAST)
                        begin
                            next_sda_oe = 1'b0;
                            next_state  = rtcs_pkg::LS_TXACK;
                        end
                        else
                        begin
                            next_bitcnt = bitcnt + 4'h1;
                            next_tx     = {tx[6:0], 1'b0};
                            next_sda_oe = ~tx[6];
                        end
                    end
                end
                default:
                begin
                    next_state  = rtcs_pkg::LS_IDLE;
                    next_sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk or posedge link_rst)
    begin
        if (link_rst)
        begin
            state      <= rtcs_pkg::LS_IDLE;
            bitcnt     <= rtcs_pkg::BIT_FIRST;
            shift      <= rtcs_pkg::BYTE_RESET;
            tx         <= rtcs_pkg::BYTE_RESET;
            is_read    <= 1'b0;
            ptr_phase  <= 1'b0;
            master_ack <= 1'b0;
            sda_oe     <= 1'b0;
            sda_o      <= 1'b0;
            req_tgl    <= 1'b0;
            start_tgl  <= 1'b0;
            ev         <= '0;
        end
        else
        begin
            state      <= next_state;
            bitcnt     <= next_bitcnt;
            shift      <= next_shift;
            tx         <= next_tx;
            is_read    <= next_is_read;
            ptr_phase  <= next_ptr_phase;
            master_ack <= next_master_ack;
            sda_oe     <= next_sda_oe;
            sda_o      <= 1'b0;
            req_tgl    <= next_req_tgl;
            start_tgl  <= next_start_tgl;
            ev         <= next_ev;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clk domain: crossings in, timeout counter

    logic                        scl_c1;
    logic                        scl_c2;
    logic [2:0]                  req_c;
    logic [2:0]                  st_c;
    logic [31:0]                 low_cnt;
    logic                        pend;
    rtcs_pkg::rtcs_event_t       ev_hold;
    logic [7:0]                  ptr;

    wire new_req  = req_c[1] ^ req_c[2];
    wire to_reach = (low_cnt == 32'(TIMEOUT_CYCLES - 1));

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            {scl_c1, scl_c2} <= 2'h3;
            req_c            <= 3'h0;
            st_c             <= 3'h0;
            snap_strobe      <= 1'b0;
        end
        else
        begin
            {scl_c1, scl_c2} <= {scl_i, scl_c1};
            req_c            <= {req_c[1:0], req_tgl};
            st_c             <= {st_c[1:0], start_tgl};
            snap_strobe      <= st_c[1] ^ st_c[2];
        end
    end

    // counts only while clock is low; fires once per low stretch
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            low_cnt <= 32'h0000_0000;
            to_tgl  <= 1'b0;
        end
        else if (scl_c2)
        begin
            low_cnt <= 32'h0000_0000;
        end
        else if (!to_reach)
        begin
            low_cnt <= low_cnt + 32'h0000_0001;
            to_tgl  <= (low_cnt == 32'(TIMEOUT_CYCLES - 2)) ? ~to_tgl : to_tgl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clk domain: register pointer and access

    // event fields are stable while the request toggle differs from the answer
    wire [7:0] next_ptr = (new_req && ev.kind == rtcs_pkg::EV_PTR)  ? ev.data
                        : (new_req && ev.kind == rtcs_pkg::EV_SENT) ? ptr + 8'h01
                        : (pend && ev_hold.kind == rtcs_pkg::EV_WR) ? ptr + 8'h01
                        : ptr;
    wire fetch = pend & ((ev_hold.kind == rtcs_pkg::EV_RD) | (ev_hold.kind == rtcs_pkg::EV_SENT));

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ptr       <= rtcs_pkg::PTR_RESET;
            pend      <= 1'b0;
            ev_hold   <= '0;
            reg_wr_en <= 1'b0;
            reg_wdata <= rtcs_pkg::BYTE_RESET;
            rd_byte   <= rtcs_pkg::BYTE_RESET;
            ack_tgl   <= 1'b0;
        end
        else
        begin
            ptr       <= next_ptr;
            pend      <= new_req;
            ev_hold   <= new_req ? ev : ev_hold;
            reg_wr_en <= new_req & (ev.kind == rtcs_pkg::EV_WR);
            reg_wdata <= new_req ? ev.data : reg_wdata;
            rd_byte   <= fetch ? reg_rdata : rd_byte;
            ack_tgl   <= pend ? req_c[2] : ack_tgl;
        end
    end

    assign reg_addr = ptr;

endmodule

`default_nettype wire

// File: rtcs_pkg.sv
// shared constants and types for the two-wire clock-calendar target port
package rtcs_pkg;

    // fixed seven-bit target address
    localparam logic [6:0] DEV_ADDR       = 7'h68;

    // bit counter landmarks within one byte
    localparam logic [3:0] BIT_FIRST      = 4'h0;
    localparam logic [3:0] BIT_LAST       = 4'h7;
    localparam logic [3:0] BIT_DONE       = 4'h8;

    // values after reset
    localparam logic [7:0] PTR_RESET      = 8'h00;
    localparam logic [7:0] BYTE_RESET     = 8'h00;

    // serial clock low timeout
    localparam int         CLK_HZ         = 10_000_000;
    localparam int         TIMEOUT_MS     = 35;
    localparam int         TIMEOUT_CYCLES = TIMEOUT_MS * (CLK_HZ / 1000);

    // work handed from the link domain to the register side
    typedef enum logic [1:0] {
        EV_PTR,
        EV_WR,
        EV_RD,
        EV_SENT
    } rtcs_ev_kind_t;

    typedef struct packed {
        rtcs_ev_kind_t kind;
        logic [7:0]    data;
    } rtcs_event_t;

    // link side byte sequencer
    typedef enum logic [2:0] {
        LS_IDLE,
        LS_ADDR,
        LS_ACK,
        LS_RX,
        LS_TX,
        LS_TXACK
    } rtcs_link_state_t;

endpackage

// File: rtcs_target_props.sv
// assertion checker for the two-wire target port
`timescale 1ns/10ps
`default_nettype none

module rtcs_target_props #(
    parameter int TIMEOUT_CYCLES = 200
) (
    // clocks and reset
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       link_clk,
    // bus pins
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic       sda_o,
    input  wire logic       sda_oe,
    // register side
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr_en,
    input  wire logic [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       snap_strobe
);
    ////////////////////////////////////////////////////////////////////////////////
    // clock low length in clk cycles
    int low_cnt;
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            low_cnt <= 0;
        else if (scl_i)
            low_cnt <= 0;
        else
            low_cnt <= low_cnt + 1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    property p_sda_o_low;
        @(posedge clk) disable iff (reset) sda_o == 1'b0;
    endproperty
    a_sda_o_low: assert property (p_sda_o_low) else $error("data output not low");

    property p_wr_pulse;
        @(posedge clk) disable iff (reset) reg_wr_en |=> !reg_wr_en;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");

    property p_ptr_inc;
        @(posedge clk) disable iff (reset) reg_wr_en |=> reg_addr == $past(reg_addr) + 8'h01;
    endproperty
    a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not advanced");

    property p_snap_pulse;
        @(posedge clk) disable iff (reset) snap_strobe |=> !snap_strobe;
    endproperty
    a_snap_pulse: assert property (p_snap_pulse) else $error("snapshot strobe too long");

    property p_snap_on_start;
        @(posedge clk) disable iff (reset) (scl_i && $fell(sda_i)) |-> ##[1:12] snap_strobe;
    endproperty
    a_snap_on_start: assert property (p_snap_on_start) else $error("no snapshot");

    property p_oe_rise_scl_low;
        @(posedge link_clk) disable iff (reset) $rose(sda_oe) |-> !scl_i;
    endproperty
    a_oe_rise_scl_low: assert property (p_oe_rise_scl_low) else $error("pull with clock high");

    property p_oe_steady_scl_high;
        @(posedge link_clk) disable iff (reset) scl_i |-> $stable(sda_oe);
    endproperty
    a_oe_steady_scl_high: assert property (p_oe_steady_scl_high) else $error("data moved");

    property p_timeout_release;
        @(posedge clk) disable iff (reset) (low_cnt > TIMEOUT_CYCLES + 20) |-> !sda_oe;
    endproperty
    a_timeout_release: assert property (p_timeout_release) else $error("held after timeout");
endmodule

`default_nettype wire

// File: rtcs_ctrl_model.sv
// two-wire bus controller model for the target port
`timescale 1ns/10ps
`default_nettype none

module rtcs_ctrl_model (
    // timing reference
    input  wire logic clk,
    // bus lines
    output logic      scl,
    output logic      sda,
    input  wire logic sda_line
);
    int n_start = 0;

    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // quarter of a bit period, 500 ns
    task automatic q();
        repeat (5) @(posedge clk);
    endtask

    // start or repeated start; controller alone makes clock and conditions
    task automatic start();
        n_start++;
        sda <= 1'b1;
        q();
        scl <= 1'b1;
        q();
        sda <= 1'b0;
        q();
        scl <= 1'b0;
        q();
    endtask

    task automatic stop();
        sda <= 1'b0;
        q();
        scl <= 1'b1;
        q();
        sda <= 1'b1;
        q();
    endtask

    // one clock pulse; the line is sampled in the middle of the high phase
    task automatic bit_io(input logic b, output logic r);
        sda <= b;
        q();
        scl <= 1'b1;
        q();
        r = sda_line;
        q();
        scl <= 1'b0;
        q();
    endtask

    // address bytes carry the direction bit in bit 0
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    task automatic rd_byte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, b[i]);
        bit_io(last, r);
    endtask

    task automatic hold_low(input int n);
        repeat (n) @(posedge clk);
    endtask
endmodule

`default_nettype wire

// File: rtcs_target_tb_top.sv
// testbench for the two-wire target port
`timescale 1ns/10ps
`default_nettype none

module rtcs_target_tb_top;
    typedef struct packed {
        logic [7:0] ptr;
        logic [7:0] data;
    } rtcs_row_t;

    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic       link_clk = 1'b0;
    wire  logic scl;
    wire  logic sda_drv;
    wire  logic sda_o;
    wire  logic sda_oe;
    wire  logic [7:0] reg_addr;
    wire  logic reg_wr_en;
    wire  logic [7:0] reg_wdata;
    wire  logic snap_strobe;
    wire  logic [7:0] reg_rdata;
    wire  logic sda_line;
    logic [7:0] mem [256];
    int         fail_count = 0;
    int         n_tests = 0;
    int         n_wr = 0;
    int         n_snap = 0;
    int         cycles = 0;
    logic       ack;
    logic [7:0] d;
    rtcs_row_t  r;
    rtcs_row_t  rows [3] = '{'{8'h00, 8'ha5}, '{8'h07, 8'h3c}, '{8'hff, 8'h81}};
    logic [7:0] bad [2] = '{8'hd2, 8'h50};

    always #50 clk = ~clk;
    initial
    begin
        #7;
        forever #15 link_clk = ~link_clk;
    end

    // open-drain data line with pull-up
    assign sda_line = sda_drv & ~sda_oe;
    assign reg_rdata = mem[reg_addr];

    rtcs_target #(.TIMEOUT_CYCLES(200)) dut (
        .clk(clk), .reset(reset), .link_clk(link_clk), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .snap_strobe(snap_strobe));

    rtcs_ctrl_model ctrl (.clk(clk), .scl(scl), .sda(sda_drv), .sda_line(sda_line));

    ////////////////////////////////////////////////////////////////////////////////
    // register space, strobe counters and hang guard
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (reg_wr_en === 1'b1)
        begin
            mem[reg_addr] <= reg_wdata;
            n_wr++;
        end
        if (snap_strobe === 1'b1)
            n_snap++;
        if (cycles == 30000)
        begin
            fail_count++;
            summarize();
        end
    end

    task automatic chk8(input string name, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic chk1(input string name, input logic e, input logic g);
        n_tests++;
        if (g !== e)
        begin
            fail_count++;
            $display("FAIL %s expected %b seen %b", name, e, g);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i) ^ 8'h5a;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        repeat (10) @(posedge clk);
        chk8("reset pointer", 8'h00, reg_addr);
        chk1("reset pull", 1'b0, sda_oe);
        // write two bytes, then pointer write and repeated start read
        for (int i = 0; i < 3; i++)
        begin
            r = rows[i];
            ctrl.start();
            ctrl.wr_byte(8'hd0, ack);
            chk1("write address ack", 1'b1, ack);
            ctrl.wr_byte(r.ptr, ack);
            chk1("pointer ack", 1'b1, ack);
            ctrl.wr_byte(r.data, ack);
            chk1("data ack", 1'b1, ack);
            ctrl.wr_byte(~r.data, ack);
            chk1("data ack", 1'b1, ack);
            ctrl.stop();
            repeat (20) @(posedge clk);
            chk8("pointer after write", r.ptr + 8'h02, reg_addr);
            chk8("first stored", r.data, mem[r.ptr]);
            chk8("second stored", ~r.data, mem[r.ptr + 8'h01]);
            ctrl.start();
            ctrl.wr_byte(8'hd0, ack);
            ctrl.wr_byte(r.ptr, ack);
            ctrl.start();
            ctrl.wr_byte(8'hd1, ack);
            chk1("read address ack", 1'b1, ack);
            ctrl.rd_byte(1'b0, d);
            chk8("first read", r.data, d);
            ctrl.rd_byte(1'b1, d);
            chk8("second read", ~r.data, d);
            ctrl.stop();
            repeat (20) @(posedge clk);
            chk8("pointer after read", r.ptr + 8'h02, reg_addr);
        end
        // pointer only, then read from the stored pointer
        ctrl.start();
        ctrl.wr_byte(8'hd0, ack);
        ctrl.wr_byte(8'h40, ack);
        ctrl.stop();
        ctrl.start();
        ctrl.wr_byte(8'hd1, ack);
        ctrl.rd_byte(1'b1, d);
        ctrl.stop();
        chk8("current pointer read", 8'h40 ^ 8'h5a, d);
        // foreign addresses are ignored
        for (int i = 0; i < 2; i++)
        begin
            ctrl.start();
            ctrl.wr_byte(bad[i], ack);
            chk1("foreign address ack", 1'b0, ack);
            ctrl.wr_byte(8'h00, ack);
            chk1("ignored byte ack", 1'b0, ack);
            ctrl.stop();
        end
        // clock held low mid-byte until the interface gives up
        ctrl.start();
        ctrl.wr_byte(8'hd0, ack);
        for (int i = 0; i < 3; i++)
            ctrl.bit_io(1'b0, ack);
        ctrl.hold_low(400);
        for (int i = 0; i < 5; i++)
            ctrl.bit_io(1'b1, ack);
        ctrl.bit_io(1'b1, ack);
        chk1("line after timeout", 1'b1, ack);
        ctrl.stop();
        repeat (20) @(posedge clk);
        chk8("write strobes", 8'h06, 8'(n_wr));
        chk8("snapshots", 8'(ctrl.n_start), 8'(n_snap));
        summarize();
    end
endmodule

bind rtcs_target rtcs_target_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_props (
    .clk(clk), .reset(reset), .link_clk(link_clk), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .snap_strobe(snap_strobe));

`default_nettype wire
